// file: inc/mcdp_defs.svh
// Register offsets, reset values and arithmetic constants of the codec path
`ifndef MCDP_DEFS_SVH
`define MCDP_DEFS_SVH

// Byte offsets on the register bus
`define MCDP_OFS_CTRL    8'h00
`define MCDP_OFS_GAIN    8'h04
`define MCDP_OFS_ANA     8'h08
`define MCDP_OFS_STAT    8'h0C
`define MCDP_OFS_ENERGY  8'h10
`define MCDP_OFS_ADC     8'h14
`define MCDP_OFS_DAC     8'h18
`define MCDP_CFG_PAGE    2'h1
`define MCDP_CFG_WORDS   4'hC

// Index of each configuration word
`define MCDP_IDX_GAIN    0
`define MCDP_IDX_B01     1
`define MCDP_IDX_B02     2
`define MCDP_IDX_A01     3
`define MCDP_IDX_A02     4
`define MCDP_IDX_B11     5
`define MCDP_IDX_B12     6
`define MCDP_IDX_A11     7
`define MCDP_IDX_A12     8
`define MCDP_IDX_DCB     9
`define MCDP_IDX_THR     10
`define MCDP_IDX_EGAIN   11

// Reset values
`define MCDP_RST_WORD    16'h0000
`define MCDP_RST_UNITY   16'h0400
`define MCDP_RST_REG     32'h0000_0000
`define MCDP_RST_LINE    1'b1

// Arithmetic: Q1.10 coefficients, Q8.8 gains, fine step in 1/8192
`define MCDP_FRAC        10
`define MCDP_LIN_SHIFT   8
`define MCDP_FINE_ONE    32'h0000_2000
`define MCDP_FINE_STEP   32'h0000_001E
`define MCDP_FINE_SHIFT  13
`define MCDP_ENERGY_SH   4
`define MCDP_SAT_MAX     32'sh0000_7FFF
`define MCDP_SAT_MIN     32'shFFFF_8000
`define MCDP_SIGN_FLIP   16'h8000

// Analogue input: codes below this are under 24 dB
`define MCDP_LINE_LIMIT  4'h9
`define MCDP_MIC_OFFSET  4'h8
`define MCDP_STAGE2_MAX  3'h7

`endif

// file: inc/mcdp_pkg.sv
// Types of the mono codec digital path
package mcdp_pkg;

  // Control register
  typedef struct packed {
    logic [24:0] pad;
    logic        inject_post;
    logic        tap_post;
    logic        st_on;
    logic        commit;
    logic        hires_dac;
    logic        hires_adc;
    logic        filt_en;
  } mcdp_ctrl_t;

  // Digital gain register
  typedef struct packed {
    logic [13:0] pad;
    logic [4:0]  dac_fine;
    logic [4:0]  adc_fine;
    logic [3:0]  dac_sel;
    logic [3:0]  adc_sel;
  } mcdp_gain_t;

  // Analogue code register
  typedef struct packed {
    logic [9:0]  pad;
    logic [3:0]  st_atten;
    logic [3:0]  bias_current_code;
    logic [3:0]  bias_voltage_code;
    logic [2:0]  out_code;
    logic [2:0]  dac_code;
    logic [3:0]  adc_code;
  } mcdp_ana_t;

  // Avalon-MM request from the master
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } mcdp_avs_req_t;

  // Codes driven to the analogue blocks
  typedef struct packed {
    logic        line_mode;
    logic        first_stage_on;
    logic [2:0]  second_stage_code;
    logic [2:0]  dac_code;
    logic [2:0]  out_code;
    logic [3:0]  bias_voltage_code;
    logic [3:0]  bias_current_code;
  } mcdp_ana_out_t;

  // State of the main module
  typedef struct packed {
    logic              ack;
    logic [31:0]       rdata;
    mcdp_ctrl_t        ctrl;
    mcdp_gain_t        gain;
    mcdp_ana_t         ana;
    logic [11:0][15:0] pend;
    logic [11:0][15:0] live;
    logic [5:0][15:0]  hist;
    logic [15:0]       energy;
    logic              filt_on;
    logic [15:0]       adc_res;
    logic              adc_val;
    logic [15:0]       dac_pcm;
    logic [15:0]       st_smp;
    logic [15:0]       dac_mix;
    mcdp_ana_out_t     aout;
  } mcdp_state_t;

  // State of the bit stream modulator
  typedef struct packed {
    logic [15:0] acc;
    logic        pos;
    logic        neg;
  } mcdp_sd_t;

endpackage : mcdp_pkg

// file: design/mcdp_bitstream.sv
// First-order modulator from 16-bit PCM to a differential bit stream
`include "mcdp_defs.svh"

module mcdp_bitstream (
  input  wire logic  sys_clk,
  input  wire logic  reset_n,
  input  wire logic [15:0] pcm_in,
  output logic       bit_pos,
  output logic       bit_neg
);
  import mcdp_pkg::*;

  mcdp_sd_t s;
  mcdp_sd_t next_s;
  logic [16:0] sum;

  // Offset-binary accumulate, carry is the output bit
  always_comb begin
    next_s = s;
    sum = {1'b0, s.acc} + {1'b0, pcm_in ^ `MCDP_SIGN_FLIP};
    next_s.acc = sum[15:0];
    next_s.pos = sum[16];
    next_s.neg = ~sum[16];
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign bit_pos = s.pos;
  assign bit_neg = s.neg;

endmodule : mcdp_bitstream

// file: design/mcdp_codec_path.sv
// Digital path of the mono codec: gains, IIR filter, side tone, registers
//
// Behaviour
// - ADC digital gain: 4-bit select, table
// - DAC digital gain uses same table
// - High-resolution gain mode, 1/32 dB steps
// - DAC analogue gain 3-bit code, 3dB steps
// - ADC analogue: bypass/24dB stage plus steps
// - Gain under 24dB selects line mode
// - 16-bit PCM converted to bit stream
// - Output stage gain 3-bit divider code
// - Side tone enable, gain, tap, inject
// - Gain times two cascaded biquad sections
// - DC blocking multiplies by one minus delay
// - Ten filter configuration words
// - Coefficients 12-bit Q1.10 twos complement
// - Words in index order, word 9 DC
// - Twelve stored values incl threshold, gain
// - Filter disabled after initialisation
// - Energy above threshold switches filter on
// - Bias voltage and current 4-bit codes
`include "mcdp_defs.svh"

module mcdp_codec_path (
  input  wire logic                    sys_clk,
  input  wire logic                    reset_n,
  input  wire mcdp_pkg::mcdp_avs_req_t avs,
  output logic [31:0]                  avs_readdata,
  output logic                         avs_waitrequest,
  input  wire logic [15:0]             conv_in_pcm,
  input  wire logic                    conv_in_valid,
  output logic [15:0]                  adc_result,
  output logic                         adc_result_valid,
  output mcdp_pkg::mcdp_ana_out_t      ana_out,
  output logic                         speaker_out_positive,
  output logic                         speaker_out_negative
);
  import mcdp_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Arithmetic helpers

  // Saturate to 16-bit signed
  function automatic logic [15:0] sat16(input logic signed [31:0] v);
    if (v > `MCDP_SAT_MAX) begin
      sat16 = 16'h7FFF;
    end else if (v < `MCDP_SAT_MIN) begin
      sat16 = 16'h8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction : sat16

  // Select value to Q8.8 linear gain, with fine trim
  function automatic logic [15:0] gain_lin(input logic [3:0] sel,
                                           input logic       hires,
                                           input logic [4:0] fine);
    logic [11:0] base;
    logic [31:0] prod;
    unique case (sel)
      4'h0: base = 12'h100;
      4'h1: base = 12'h17F;
      4'h2: base = 12'h1FF;
      4'h3: base = 12'h2FC;
      4'h4: base = 12'h3FB;
      4'h5: base = 12'h5F5;
      4'h6: base = 12'h7F1;
      4'h7: base = 12'hBE3;
      4'h8: base = 12'h010;
      4'h9: base = 12'h018;
      4'hA: base = 12'h020;
      4'hB: base = 12'h030;
      4'hC: base = 12'h040;
      4'hD: base = 12'h060;
      4'hE: base = 12'h080;
      4'hF: base = 12'h0C0;
    endcase
    prod = {20'h0_0000, base} * (hires ? (`MCDP_FINE_ONE +
           {27'h000_0000, fine} * `MCDP_FINE_STEP) : `MCDP_FINE_ONE);
    gain_lin = prod[`MCDP_FINE_SHIFT +: 16];
  endfunction : gain_lin

  // Apply Q8.8 linear gain to a sample
  function automatic logic [15:0] apply_gain(input logic [15:0] v,
                                             input logic [15:0] lin);
    logic signed [31:0] p;
    p = 32'(signed'(v)) * signed'({16'h0000, lin});
    apply_gain = sat16(p >>> `MCDP_LIN_SHIFT);
  endfunction : apply_gain

  // Sample times Q1.10 coefficient held in the low 12 bits
  function automatic logic signed [31:0] mulq(input logic [15:0] v,
                                              input logic [15:0] c);
    mulq = 32'(signed'(v)) * 32'(signed'(c[11:0]));
  endfunction : mulq

  // One second-order section, leading coefficients one
  function automatic logic [15:0] sect(input logic [15:0] x,
    input logic [15:0] x1, input logic [15:0] x2,
    input logic [15:0] y1, input logic [15:0] y2,
    input logic [15:0] b1, input logic [15:0] b2,
    input logic [15:0] a1, input logic [15:0] a2);
    logic signed [31:0] acc;
    acc = (32'(signed'(x)) <<< `MCDP_FRAC) + mulq(x1, b1) + mulq(x2, b2)
          - mulq(y1, a1) - mulq(y2, a2);
    sect = sat16(acc >>> `MCDP_FRAC);
  endfunction : sect

  //////////////////////////////////////////////////////////////////////////
  // State and datapath

  mcdp_state_t s;
  mcdp_state_t next_s;
  logic [15:0] adc_lin;
  logic [15:0] dac_lin;
  logic [15:0] adc_gained;
  logic [15:0] xg;
  logic [15:0] y0;
  logic [15:0] y1;
  logic [15:0] yd;
  logic [15:0] filt_out;
  logic [15:0] st_src;
  logic [15:0] dac_pre;
  logic [15:0] dac_abs;
  logic [3:0]  cfg_idx;
  logic        cfg_hit;
  logic        rd_go;
  logic        wr_go;
  logic signed [31:0] e_step;

  // Bus handshake: one wait cycle per request
  assign rd_go   = avs.read & ~s.ack;
  assign wr_go   = avs.write & s.ack;
  assign cfg_idx = avs.address[5:2];
  assign cfg_hit = (avs.address[7:6] == `MCDP_CFG_PAGE) &&
                   (cfg_idx < `MCDP_CFG_WORDS);
  assign avs_waitrequest = (avs.read | avs.write) & ~s.ack;

  always_comb begin
    next_s = s;
    // Digital gains from the shared table
    adc_lin = gain_lin(s.gain.adc_sel, s.ctrl.hires_adc,
                       s.gain.adc_fine);
    dac_lin = gain_lin(s.gain.dac_sel, s.ctrl.hires_dac,
                       s.gain.dac_fine);
    adc_gained = apply_gain(conv_in_pcm, adc_lin);
    // Gain term, two sections, optional first difference
    xg = sat16(mulq(adc_gained, s.live[`MCDP_IDX_GAIN])
               >>> `MCDP_FRAC);
    y0 = sect(xg, s.hist[0], s.hist[1], s.hist[2], s.hist[3],
              s.live[`MCDP_IDX_B01], s.live[`MCDP_IDX_B02],
              s.live[`MCDP_IDX_A01], s.live[`MCDP_IDX_A02]);
    y1 = sect(y0, s.hist[2], s.hist[3], s.hist[4], s.hist[5],
              s.live[`MCDP_IDX_B11], s.live[`MCDP_IDX_B12],
              s.live[`MCDP_IDX_A11], s.live[`MCDP_IDX_A12]);
    yd = s.live[`MCDP_IDX_DCB][0] ?
         sat16(32'(signed'(y1)) - 32'(signed'(s.hist[4]))) : y1;
    // Echo gain while filtering, zero word means unity
    if (s.live[`MCDP_IDX_EGAIN] != `MCDP_RST_WORD) begin
      filt_out = sat16(mulq(yd, s.live[`MCDP_IDX_EGAIN])
                       >>> `MCDP_FRAC);
    end else begin
      filt_out = yd;
    end
    if (!s.filt_on) begin
      filt_out = adc_gained;
    end
    // Side tone source and attenuation
    st_src = s.ctrl.tap_post ? filt_out : conv_in_pcm;
    next_s.adc_val = conv_in_valid;
    if (conv_in_valid) begin
      next_s.adc_res = filt_out;
      next_s.st_smp = s.ctrl.st_on ?
        16'(signed'(st_src) >>> s.ana.st_atten) : 16'h0000;
      if (s.filt_on) begin
        next_s.hist = {yd, y1, y1, y0, xg, xg};
        next_s.hist[5] = s.hist[4];
        next_s.hist[4] = y1;
        next_s.hist[3] = s.hist[2];
        next_s.hist[2] = y0;
        next_s.hist[1] = s.hist[0];
        next_s.hist[0] = xg;
      end
    end
    if (!s.filt_on) begin
      next_s.hist = '0;
    end
    // Side tone before or after the DAC digital gain
    dac_pre = s.ctrl.inject_post ? s.dac_pcm :
      sat16(32'(signed'(s.dac_pcm)) + 32'(signed'(s.st_smp)));
    next_s.dac_mix = apply_gain(dac_pre, dac_lin);
    if (s.ctrl.inject_post) begin
      next_s.dac_mix = sat16(32'(signed'(next_s.dac_mix)) +
                             32'(signed'(s.st_smp)));
    end
    // Energy-driven filter switching, off until enabled
    next_s.filt_on = s.ctrl.filt_en &&
      (s.energy >= s.live[`MCDP_IDX_THR]);
    // Pending words go live only on a cycle with no sample
    if (s.ctrl.commit && !conv_in_valid) begin
      next_s.live = s.pend;
      next_s.ctrl.commit = 1'b0;
    end
    // Voice link energy estimate from received samples
    dac_abs = s.dac_pcm[15] ? 16'(-signed'(s.dac_pcm)) : s.dac_pcm;
    e_step = (signed'(32'(dac_abs)) - signed'(32'(s.energy)))
             >>> `MCDP_ENERGY_SH;
    next_s.energy = 16'(32'(s.energy) + e_step);
    // Register read, captured on the first cycle
    next_s.ack = (avs.read | avs.write) & ~s.ack;
    if (rd_go) begin
      next_s.rdata = `MCDP_RST_REG;
      if (cfg_hit) begin
        next_s.rdata = {16'h0000, s.pend[cfg_idx]};
      end else begin
        unique case (avs.address)
          `MCDP_OFS_CTRL:   next_s.rdata = 32'(s.ctrl);
          `MCDP_OFS_GAIN:   next_s.rdata = 32'(s.gain);
          `MCDP_OFS_ANA:    next_s.rdata = 32'(s.ana);
          `MCDP_OFS_STAT:   next_s.rdata = {29'h0000_0000, s.ctrl.commit,
                              s.aout.line_mode, s.filt_on};
          `MCDP_OFS_ENERGY: next_s.rdata = {16'h0000, s.energy};
          `MCDP_OFS_ADC:    next_s.rdata = {16'h0000, s.adc_res};
          `MCDP_OFS_DAC:    next_s.rdata = {16'h0000, s.dac_pcm};
          default:          next_s.rdata = `MCDP_RST_REG;
        endcase
      end
    end
    // Register write, taken at the edge that ends the cycle after the wait
    if (wr_go) begin
      if (cfg_hit) begin
        next_s.pend[cfg_idx] = avs.writedata[15:0];
      end else begin
        unique case (avs.address)
          `MCDP_OFS_CTRL: begin
            next_s.ctrl = mcdp_ctrl_t'(avs.writedata);
            next_s.ctrl.pad = '0;
            next_s.ctrl.commit = next_s.ctrl.commit | s.ctrl.commit &
                                 ~(!conv_in_valid);
          end
          `MCDP_OFS_GAIN: begin
            next_s.gain = mcdp_gain_t'(avs.writedata);
            next_s.gain.pad = '0;
          end
          `MCDP_OFS_ANA: begin
            next_s.ana = mcdp_ana_t'(avs.writedata);
            next_s.ana.pad = '0;
          end
          `MCDP_OFS_DAC: next_s.dac_pcm = avs.writedata[15:0];
          default: ;
        endcase
      end
    end
    // Analogue control codes
    next_s.aout.line_mode = s.ana.adc_code < `MCDP_LINE_LIMIT;
    next_s.aout.first_stage_on = !next_s.aout.line_mode;
    if (next_s.aout.line_mode) begin
      next_s.aout.second_stage_code = (s.ana.adc_code[3]) ?
        `MCDP_STAGE2_MAX : s.ana.adc_code[2:0];
    end else begin
      next_s.aout.second_stage_code =
        3'(s.ana.adc_code - `MCDP_MIC_OFFSET);
    end
    next_s.aout.dac_code = s.ana.dac_code;
    next_s.aout.out_code = s.ana.out_code;
    next_s.aout.bias_voltage_code = s.ana.bias_voltage_code;
    next_s.aout.bias_current_code = s.ana.bias_current_code;
  end

  // State register with synchronous reset
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s <= '0;
      s.pend[`MCDP_IDX_GAIN] <= `MCDP_RST_UNITY;
      s.live[`MCDP_IDX_GAIN] <= `MCDP_RST_UNITY;
      s.aout.line_mode <= `MCDP_RST_LINE;
    end else begin
      s <= next_s;
    end
  end

  // Outputs from the state register
  assign avs_readdata     = s.rdata;
  assign adc_result       = s.adc_res;
  assign adc_result_valid = s.adc_val;
  assign ana_out          = s.aout;

  // Bit stream to the output stage
  mcdp_bitstream u_bits (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .pcm_in  (s.dac_mix),
    .bit_pos (speaker_out_positive),
    .bit_neg (speaker_out_negative)
  );

  //////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  a_bus_wait_one: assert property ((avs.read | avs.write) && !s.ack
    |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait cycle");

  a_adc_gain_neg: assert property (s.gain.adc_sel == 4'h8 &&
    !s.ctrl.hires_adc |-> adc_lin == 16'h0010)
    else $error("adc gain select 8 not -24 dB");

  a_dac_gain_top: assert property (s.gain.dac_sel == 4'h7 &&
    !s.ctrl.hires_dac |-> dac_lin == 16'h0BE3)
    else $error("dac gain select 7 not 21.5 dB");

  a_hires_trim: assert property (s.ctrl.hires_adc &&
    s.gain.adc_fine != 5'h00 && s.gain.adc_sel == 4'h7
    |-> adc_lin > 16'h0BE3)
    else $error("fine trim does not raise gain");

  a_line_mode: assert property ($changed(s.ana.adc_code)
    |=> s.aout.line_mode == ($past(s.ana.adc_code) < 4'h9)
    && s.aout.first_stage_on != s.aout.line_mode)
    else $error("line mode not following gain code");

  a_filter_off: assert property (!s.ctrl.filt_en [*2]
    |-> !s.filt_on)
    else $error("filter on while disabled");

  a_energy_on: assert property (s.ctrl.filt_en &&
    s.energy >= s.live[`MCDP_IDX_THR] |=> s.filt_on)
    else $error("filter not switched on above threshold");

  a_commit_gap: assert property ($changed(s.live)
    |-> !$past(conv_in_valid) && $past(s.ctrl.commit))
    else $error("coefficients changed during a sample");

  a_bypass_pass: assert property (!s.filt_on && conv_in_valid
    |=> adc_result_valid && adc_result == $past(adc_gained))
    else $error("bypass sample not passed through");

  c_filter_rise: cover property ($rose(s.filt_on));
  c_commit_apply: cover property ($changed(s.live));
  c_dc_sample: cover property (s.filt_on && conv_in_valid &&
    s.live[`MCDP_IDX_DCB][0]);
  c_sidetone: cover property (s.ctrl.st_on && s.st_smp != 16'h0000);

endmodule : mcdp_codec_path

// file: testbench/mcdp_pcm_source.sv
// Converter-side model that hands PCM samples to the codec path
module mcdp_pcm_source (
  input  wire logic   sys_clk,
  output logic [15:0] conv_in_pcm,
  output logic        conv_in_valid
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus at time zero
  initial begin
    conv_in_pcm   = 16'hA5A5;
    conv_in_valid = 1'b0;
  end

  // One sample per call, called just after a rising edge; gap sets the rate
  task automatic put(input logic [15:0] smp, input int gap);
    conv_in_pcm   <= smp;
    conv_in_valid <= 1'b1;
    @(posedge sys_clk);
    if (gap > 0) begin
      conv_in_valid <= 1'b0;
      conv_in_pcm   <= ~smp; // Stale data never looks valid
      repeat (gap) @(posedge sys_clk);
    end
  endtask : put
endmodule : mcdp_pcm_source

// file: testbench/mono_codec_digital_path_tb.sv
// Self-checking bench for the mono codec digital path
module mono_codec_digital_path_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import mcdp_pkg::*;

  logic                 sys_clk;
  logic                 reset_n;
  mcdp_avs_req_t        avs;
  logic [31:0]          avs_readdata;
  logic                 avs_waitrequest;
  logic [15:0]          conv_in_pcm;
  logic                 conv_in_valid;
  logic [15:0]          adc_result;
  logic                 adc_result_valid;
  mcdp_ana_out_t        ana_out;
  logic                 spk_p;
  logic                 spk_n;
  int                   miscompares;
  int                   n_checks;
  int                   cycles;
  int                   seed;
  logic [15:0]          got_q[$];
  logic [15:0]          exp_q[$];
  logic [31:0]          rd;
  logic [15:0]          x;
  logic [15:0]          xm1;
  logic [15:0]          xm2;
  logic [31:0]          r;
  mcdp_ana_t            a;
  logic [11:0][15:0]    cfg;
  int                   sels[3] = '{0, 8, 15};

  ////////////////////////////////////////////////////////////////////////////
  // Clock, design and converter model
  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;

  mcdp_codec_path dut (
    .sys_clk              (sys_clk),
    .reset_n              (reset_n),
    .avs                  (avs),
    .avs_readdata         (avs_readdata),
    .avs_waitrequest      (avs_waitrequest),
    .conv_in_pcm          (conv_in_pcm),
    .conv_in_valid        (conv_in_valid),
    .adc_result           (adc_result),
    .adc_result_valid     (adc_result_valid),
    .ana_out              (ana_out),
    .speaker_out_positive (spk_p),
    .speaker_out_negative (spk_n)
  );

  mcdp_pcm_source src (
    .sys_clk       (sys_clk),
    .conv_in_pcm   (conv_in_pcm),
    .conv_in_valid (conv_in_valid)
  );

  // Collect results and cut a hang short
  always @(posedge sys_clk) begin
    if (adc_result_valid === 1'b1) got_q.push_back(adc_result);
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tasks and expectations
  task automatic print_verdict;
    if (miscompares == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  // Avalon access: hold the request until waitrequest is seen low
  task automatic bus(input logic [7:0] ad, input logic wr,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs.address   <= ad;
    avs.write     <= wr;
    avs.read      <= !wr;
    avs.writedata <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40) miscompares++;
    q = avs_readdata;
    avs.read  <= 1'b0;
    avs.write <= 1'b0;
  endtask : bus

  task automatic rchk(input logic [7:0] ad, input logic [31:0] e);
    bus(ad, 1'b0, 32'h0000_0000, rd);
    check($sformatf("reg_%h", ad), e, rd);
  endtask : rchk

  task automatic cmp_q(input string nm);
    check({nm, "_count"}, 32'(exp_q.size()), 32'(got_q.size()));
    foreach (exp_q[i]) if (i < got_q.size()) check(nm, exp_q[i], got_q[i]);
    exp_q.delete();
    got_q.delete();
  endtask : cmp_q

  // Count stream ones for a fixed DAC word, and complement of the pair
  task automatic density(input logic [31:0] d, input int lo, input int hi);
    int ones;
    int bad;
    ones = 0;
    bad = 0;
    bus(8'h18, 1'b1, d, rd);
    repeat (20) @(posedge sys_clk);
    repeat (200) begin
      @(negedge sys_clk);
      ones += int'(spk_p === 1'b1);
      bad += int'(spk_n !== ~spk_p);
    end
    check("stream_density", 32'h1, 32'(ones >= lo && ones <= hi));
    check("stream_pair", 32'h0, 32'(bad));
  endtask : density

  // Q8.8 linear gain for the digital select values used here
  function automatic logic [15:0] gain_exp(input logic [15:0] v,
                                           input int sel);
    logic signed [31:0] p;
    p = $signed(v) * (sel == 0 ? 256 : (sel == 8 ? 16 : 192));
    return p[23:8];
  endfunction : gain_exp

  // Line flag, first stage on, second stage code for an input code
  function automatic logic [4:0] ana_exp(input logic [3:0] c);
    return {c < 4'h9, c >= 4'h9, (c == 4'h8) ? 3'h7 : c[2:0]};
  endfunction : ana_exp

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 69;
    miscompares = 0;
    n_checks = 0;
    cycles = 0;
    reset_n = 1'b0;
    avs = '0;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    // Reset values, unmapped and read-only places
    check("ana_rst", 32'(5'h10), 32'({ana_out.line_mode,
          ana_out.first_stage_on, ana_out.second_stage_code}));
    rchk(8'h00, 32'h0000_0000);
    rchk(8'h0C, 32'h0000_0002);
    rchk(8'h40, 32'h0000_0400);
    bus(8'h30, 1'b1, 32'hFFFF_FFFF, rd);
    bus(8'h0C, 1'b1, 32'hFFFF_FFFF, rd);
    rchk(8'h30, 32'h0000_0000);
    rchk(8'h0C, 32'h0000_0002);
    // Every analogue input code with random other codes
    for (int c = 0; c < 16; c++) begin
      r = $random(seed);
      a = '0;
      a.adc_code = 4'(c);
      {a.dac_code, a.out_code, a.bias_voltage_code, a.bias_current_code} =
        r[13:0];
      bus(8'h08, 1'b1, a, rd);
      repeat (3) @(posedge sys_clk);
      check("ana_out", 32'({ana_exp(4'(c)), r[13:0]}), 32'({ana_out.line_mode,
            ana_out.first_stage_on, ana_out.second_stage_code,
            ana_out.dac_code, ana_out.out_code, ana_out.bias_voltage_code,
            ana_out.bias_current_code}));
      rchk(8'h08, a);
    end
    // Digital input gain, random samples, random spacing
    foreach (sels[i]) begin
      bus(8'h04, 1'b1, 32'(sels[i]), rd);
      for (int k = 0; k < 12; k++) begin
        x = 16'($random(seed)) & 16'hFFF0;
        exp_q.push_back(gain_exp(x, sels[i]));
        src.put(x, (k == 11) ? 3 : ($random(seed) & 1));
      end
      cmp_q("adc_gain");
    end
    // Filter (1 + z^-1) with DC block gives x[n] - x[n-2]
    bus(8'h04, 1'b1, 32'h0000_0000, rd);
    cfg = '0;
    cfg[0] = 16'h0400;
    cfg[1] = 16'h0400;
    cfg[9] = 16'h0001;
    for (int i = 0; i < 12; i++) begin
      bus(8'(8'h40 + 4 * i), 1'b1, 32'(cfg[i]), rd);
    end
    bus(8'h00, 1'b1, 32'h0000_0009, rd);
    rchk(8'h00, 32'h0000_0001);
    rchk(8'h0C, 32'h0000_0001);
    xm1 = '0;
    xm2 = '0;
    for (int k = 0; k < 16; k++) begin
      r = $random(seed);
      x = {{3{r[12]}}, r[12:4], 4'h0};
      exp_q.push_back(x - xm2);
      xm2 = xm1;
      xm1 = x;
      src.put(x, (k == 15) ? 3 : ($random(seed) & 1));
    end
    cmp_q("filter_out");
    // Energy threshold switches the filter on and off
    bus(8'h68, 1'b1, 32'h0000_1000, rd);
    bus(8'h00, 1'b1, 32'h0000_0009, rd);
    repeat (2) @(posedge sys_clk);
    rchk(8'h0C, 32'h0000_0000);
    bus(8'h18, 1'b1, 32'h0000_2000, rd);
    rchk(8'h18, 32'h0000_2000);
    repeat (200) @(posedge sys_clk);
    rchk(8'h0C, 32'h0000_0001);
    bus(8'h18, 1'b1, 32'h0000_0000, rd);
    repeat (200) @(posedge sys_clk);
    rchk(8'h0C, 32'h0000_0000);
    // Output bit stream at both ends of the range
    density(32'h0000_7FFF, 190, 200);
    density(32'h0000_8000, 0, 10);
    // Raw side tone, halved, alone drives the output stream
    bus(8'h08, 1'b1, 32'h0004_0000, rd);
    bus(8'h00, 1'b1, 32'h0000_0010, rd);
    src.put(16'h7FFF, 3);
    density(32'h0000_0000, 145, 155);
    print_verdict();
  end
endmodule : mono_codec_digital_path_tb
